// *** inc/ddcs_pkg.sv ***
package ddcs_pkg;
    // Register indices; byte address is four times the index
    localparam int unsigned IDX_W = 12;
    localparam logic [11:0] IDX_XFER = 12'h00F;
    localparam logic [11:0] IDX_SYNC = 12'h300;
    localparam logic [11:0] IDX_FIRST_DOWNCONVERTER = 12'h310;
    localparam logic [11:0] IDX_WORD0 = 12'h314;
    localparam int unsigned NUM_WORDS = 4;
    localparam int unsigned WORD_W_DEF = 32;
    // Field positions
    localparam int unsigned XFER_BIT = 0;
    localparam int unsigned SYNC_UPD_MODE = 7;
    localparam int unsigned SYNC_SOFT_RST = 4;
    localparam int unsigned SYNC_ONE_SHOT = 1;
    localparam int unsigned SYNC_ALIGN_EN = 0;
    localparam int unsigned D0_MIXER = 7;
    localparam int unsigned D0_GAIN = 6;
    localparam int unsigned D0_IF_HI = 5;
    localparam int unsigned D0_IF_LO = 4;
    localparam int unsigned D0_C2R = 3;
    // Reset values
    localparam logic [7:0] SYNC_RESET = 8'h00;
    localparam logic [7:0] FIRST_DOWNCONVERTER_RESET = 8'h00;
    // Bus codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        DDCS_IF_VAR = 2'b00,
        DDCS_IF_ZERO = 2'b01,
        DDCS_IF_FS = 2'b10,
        DDCS_IF_TEST = 2'b11
    } ddcs_if_mode_t;

    typedef struct packed {
        logic complex_mixer;
        logic gain_x2;
        ddcs_if_mode_t if_mode;
        logic real_only;
    } ddcs_mix_t;

    typedef struct packed {
        logic update_sync;
        logic osc_soft_reset;
        logic one_shot_align;
        logic align_enable;
    } ddcs_sync_t;
endpackage

// *** rtl/ddcs_align.sv ***
`timescale 1ns/1ns
module ddcs_align
    import ddcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sysref_pin,
    input wire logic align_enable,
    input wire logic one_shot_align,
    output logic align_pulse,
    output logic align_clear
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic edge_seen;

    // Two-stage synchroniser plus a history stage for edge detection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= sysref_pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign edge_seen = sync2 & ~sync3;

    // Edges while disabled are dropped; in one-shot the enable is gone before the next edge can pass
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            align_pulse <= 1'b0;
            align_clear <= 1'b0;
        end else begin
            align_pulse <= edge_seen & align_enable; // R6
            align_clear <= edge_seen & align_enable & one_shot_align; // R5
        end
    end

    property p_pulse_cause;
        @(posedge core_clk) disable iff (!rst_b)
        align_pulse |-> $past(align_enable) && $past(sync2) && !$past(sync3);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("align pulse without enabled edge"); // R6

    property p_clear_one_shot;
        @(posedge core_clk) disable iff (!rst_b)
        align_clear |-> align_pulse && $past(one_shot_align);
    endproperty
    a_clear_one_shot: assert property (p_clear_one_shot) else $error("enable cleared outside one-shot"); // R5
endmodule

// *** rtl/ddcs_ctrl.sv ***
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// R1: Mode 0 applies oscillator words on each write
// R2: Mode 1 stages words until transfer strobe
// R3: Soft reset bit holds downconverters in reset
// R4: Continuous alignment needs integer-multiple timing reference
// R5: One-shot uses first valid edge only
// R6: Alignment enable; self-clears after one-shot event
// R7: Software enables timing input before aligning
// R8: Mixer bit selects real or complex mixer
// R9: Gain bit doubles downconverter output
// R10: Two-bit field selects intermediate-frequency mode
// R11: Complex-to-real bit keeps only real path
// R12: Fields reset zero; reserved bits read zero
module ddcs_ctrl
    import ddcs_pkg::*;
#(
    parameter int unsigned WORD_W = WORD_W_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sysref_pin,
    output logic [NUM_WORDS-1:0][WORD_W-1:0] osc_words,
    output logic osc_hold_reset,
    output logic osc_align_pulse,
    output ddcs_mix_t mixer_cfg
);
    // Elaboration check; word registers are at most one bus word wide
    if (WORD_W < 1 || WORD_W > 32) begin : g_bad_width
        $error("WORD_W must lie in 1..32");
    end

    function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] ref_idx);
        hit = (idx == ref_idx);
    endfunction

    logic dp_valid;
    logic dp_write;
    logic [IDX_W-1:0] dp_idx;
    logic [IDX_W-1:0] ap_idx;
    logic ap_take;
    logic wr;
    logic xfer_go;
    logic align_clear;
    ddcs_sync_t sync_cfg;
    logic [WORD_W-1:0] staged [NUM_WORDS];
    logic [31:0] next_rdata;

    // Zero-wait slave: every answer is OKAY and ready
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_idx = haddr[IDX_W+1:2];
    assign ap_take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    assign wr = dp_valid && dp_write;

    // Address phase capture; non-word sizes are accepted but have no effect
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_idx <= '0;
        end else begin
            dp_valid <= ap_take;
            dp_write <= hwrite;
            dp_idx <= ap_idx;
        end
    end

    // Alignment and update-mode controls; a software write wins over the self-clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_cfg <= '0; // R12
        end else if (wr && hit(dp_idx, IDX_SYNC)) begin
            sync_cfg.update_sync <= hwdata[SYNC_UPD_MODE];
            sync_cfg.osc_soft_reset <= hwdata[SYNC_SOFT_RST]; // R3
            sync_cfg.one_shot_align <= hwdata[SYNC_ONE_SHOT];
            sync_cfg.align_enable <= hwdata[SYNC_ALIGN_EN];
        end else if (align_clear) begin
            sync_cfg.align_enable <= 1'b0; // R6
        end
    end

    // First downconverter mixer setup
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mixer_cfg <= '0; // R12
        end else if (wr && hit(dp_idx, IDX_FIRST_DOWNCONVERTER)) begin
            mixer_cfg.complex_mixer <= hwdata[D0_MIXER]; // R8
            mixer_cfg.gain_x2 <= hwdata[D0_GAIN]; // R9
            mixer_cfg.if_mode <= ddcs_if_mode_t'(hwdata[D0_IF_HI:D0_IF_LO]); // R10
            mixer_cfg.real_only <= hwdata[D0_C2R]; // R11
        end
    end

    // Transfer strobe is write-only and reads back as zero
    assign xfer_go = wr && hit(dp_idx, IDX_XFER) && hwdata[XFER_BIT] && sync_cfg.update_sync; // R2

    // Staged and applied oscillator words, one pair per word
    genvar g;
    generate
        for (g = 0; g < NUM_WORDS; g++) begin : g_word
            localparam logic [IDX_W-1:0] MY_IDX = IDX_WORD0 + IDX_W'(g);
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    staged[g] <= '0;
                end else if (wr && hit(dp_idx, MY_IDX)) begin
                    staged[g] <= hwdata[WORD_W-1:0];
                end
            end
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    osc_words[g] <= '0;
                end else if (wr && hit(dp_idx, MY_IDX) && !sync_cfg.update_sync) begin
                    osc_words[g] <= hwdata[WORD_W-1:0]; // R1
                end else if (xfer_go) begin
                    osc_words[g] <= staged[g]; // R2
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses and reserved bits give zero
    always_comb begin
        next_rdata = 32'h00000000;
        if (hit(ap_idx, IDX_SYNC)) begin
            next_rdata[SYNC_UPD_MODE] = sync_cfg.update_sync;
            next_rdata[SYNC_SOFT_RST] = sync_cfg.osc_soft_reset;
            next_rdata[SYNC_ONE_SHOT] = sync_cfg.one_shot_align;
            next_rdata[SYNC_ALIGN_EN] = sync_cfg.align_enable;
        end else if (hit(ap_idx, IDX_FIRST_DOWNCONVERTER)) begin
            next_rdata[D0_MIXER] = mixer_cfg.complex_mixer;
            next_rdata[D0_GAIN] = mixer_cfg.gain_x2;
            next_rdata[D0_IF_HI:D0_IF_LO] = mixer_cfg.if_mode;
            next_rdata[D0_C2R] = mixer_cfg.real_only;
        end else begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                if (hit(ap_idx, IDX_WORD0 + IDX_W'(i))) begin
                    next_rdata[WORD_W-1:0] = staged[i];
                end
            end
        end
    end

    // Read data registered at the address phase so it stands for the whole data phase
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
        end else if (ap_take && !hwrite) begin
            hrdata <= next_rdata; // R12
        end
    end

    // Downconverters stay in reset while the bit is set; osc_hold_reset follows the bit directly
    assign osc_hold_reset = sync_cfg.osc_soft_reset; // R3

    ddcs_align u_align (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sysref_pin(sysref_pin),
        .align_enable(sync_cfg.align_enable),
        .one_shot_align(sync_cfg.one_shot_align),
        .align_pulse(osc_align_pulse),
        .align_clear(align_clear)
    );

    property p_imm_apply;
        @(posedge core_clk) disable iff (!rst_b)
        wr && hit(dp_idx, IDX_WORD0) && !sync_cfg.update_sync |=> osc_words[0] == $past(hwdata[WORD_W-1:0]);
    endproperty
    a_imm_apply: assert property (p_imm_apply) else $error("word not applied at once"); // R1

    property p_staged_hold;
        @(posedge core_clk) disable iff (!rst_b)
        sync_cfg.update_sync && !xfer_go |=> $stable(osc_words);
    endproperty
    a_staged_hold: assert property (p_staged_hold) else $error("word applied without transfer"); // R2

    property p_xfer_apply;
        @(posedge core_clk) disable iff (!rst_b)
        xfer_go |=> osc_words[1] == $past(staged[1]);
    endproperty
    a_xfer_apply: assert property (p_xfer_apply) else $error("transfer did not apply staged word"); // R2

    property p_soft_reset;
        @(posedge core_clk) disable iff (!rst_b)
        wr && hit(dp_idx, IDX_SYNC) |=> osc_hold_reset == $past(hwdata[SYNC_SOFT_RST]);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("hold reset does not follow write"); // R3

    property p_self_clear;
        @(posedge core_clk) disable iff (!rst_b)
        osc_align_pulse && $past(sync_cfg.one_shot_align) && !(wr && hit(dp_idx, IDX_SYNC)) |=> !sync_cfg.align_enable;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("enable not cleared after one-shot"); // R6

    property p_one_shot_once;
        @(posedge core_clk) disable iff (!rst_b)
        osc_align_pulse && $past(sync_cfg.one_shot_align) && !wr ##1 !wr [*4] |-> !osc_align_pulse;
    endproperty
    a_one_shot_once: assert property (p_one_shot_once) else $error("second edge used in one-shot"); // R5

    property p_mixer_fields;
        @(posedge core_clk) disable iff (!rst_b)
        wr && hit(dp_idx, IDX_FIRST_DOWNCONVERTER) |=> mixer_cfg.complex_mixer == $past(hwdata[D0_MIXER])
            && mixer_cfg.gain_x2 == $past(hwdata[D0_GAIN]);
    endproperty
    a_mixer_fields: assert property (p_mixer_fields) else $error("mixer or gain field wrong"); // R8 R9

    property p_if_c2r;
        @(posedge core_clk) disable iff (!rst_b)
        wr && hit(dp_idx, IDX_FIRST_DOWNCONVERTER) |=> mixer_cfg.if_mode == $past(hwdata[D0_IF_HI:D0_IF_LO])
            && mixer_cfg.real_only == $past(hwdata[D0_C2R]);
    endproperty
    a_if_c2r: assert property (p_if_c2r) else $error("mode or real-only field wrong"); // R10 R11

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_b)
        ap_take && !hwrite && (hit(ap_idx, IDX_SYNC) || hit(ap_idx, IDX_FIRST_DOWNCONVERTER) || hit(ap_idx, IDX_XFER))
            |=> hrdata[31:8] == 24'h000000
            && (!hit($past(ap_idx), IDX_SYNC) || (hrdata[6:5] == 2'h0 && hrdata[3:2] == 2'h0))
            && (!hit($past(ap_idx), IDX_FIRST_DOWNCONVERTER) || hrdata[2:0] == 3'h0)
            && (!hit($past(ap_idx), IDX_XFER) || hrdata[7:0] == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // R12
endmodule

// *** verification/ddcs_sysref_src.sv ***
`timescale 1ns/1ns
module ddcs_sysref_src (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [3:0] half_len,
    output logic sysref_pin
);
    logic [4:0] phase;

    // Square wave, period twice half_len; a fixed whole ratio keeps continuous alignment legal
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 5'h00;
            sysref_pin <= 1'b0;
        end else if (!run) begin
            phase <= 5'h00;
            sysref_pin <= 1'b0; // Parked low between bursts
        end else begin
            sysref_pin <= (phase < {1'b0, half_len});
            phase <= (phase == {half_len, 1'b0} - 5'h01) ? 5'h00 : phase + 5'h01;
        end
    end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb
    import ddcs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sysref_pin;
    logic run = 1'b0;
    logic [3:0] half_len = 4'h2;
    logic [NUM_WORDS-1:0][31:0] osc_words;
    logic osc_hold_reset;
    logic osc_align_pulse;
    ddcs_mix_t mixer_cfg;
    int errors = 0;
    int total_checks = 0;
    int pulses = 0;
    int seed;
    int i;
    int n0;
    logic [31:0] rd;
    logic [31:0] v;
    logic [31:0] staged [4];
    logic [31:0] applied [4];

    always #2 core_clk = ~core_clk;

    ddcs_ctrl ddcs_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sysref_pin(sysref_pin),
        .osc_words(osc_words), .osc_hold_reset(osc_hold_reset),
        .osc_align_pulse(osc_align_pulse), .mixer_cfg(mixer_cfg));

    ddcs_sysref_src ddcs_sysref_src_inst (.core_clk(core_clk), .rst_b(rst_b), .run(run),
        .half_len(half_len), .sysref_pin(sysref_pin));

    // Tally of alignment pulses, read as differences so it never needs clearing
    always @(posedge core_clk) begin
        if (osc_align_pulse === 1'b1) pulses <= pulses + 1;
    end

    task close_out;
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            errors++;
            close_out;
        end
    endtask

    task bus_write(input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b1;
        hsize <= HSIZE_WORD;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
    endtask

    task bus_read(input logic [31:0] a, output logic [31:0] d);
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b0;
        hsize <= HSIZE_WORD;
        wait_ready;
        htrans <= 2'h0;
        wait_ready;
        d = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task chk_words;
        @(negedge core_clk);
        for (int k = 0; k < 4; k++) chk("osc_word", applied[k], osc_words[k]);
    endtask

    // Timing bursts of k whole periods at a random pace, then the expected pulse count
    task burst(input int k, input int exp_n);
        int h;
        n0 = pulses;
        h = 2 + ($random(seed) & 3);
        half_len <= h[3:0];
        run <= 1'b1;
        repeat (k * 2 * h) @(posedge core_clk);
        run <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("align_pulses", exp_n, pulses - n0);
    endtask

    initial begin
        seed = 32'h8be2;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        hsel <= 1'b1;
        @(posedge core_clk);
        bus_read(32'h00000C00, rd);
        chk("sync_reg", 32'h0, rd);
        bus_read(32'h00000C40, rd);
        chk("first_downconverter_reg", 32'h0, rd);
        // Every IF mode with random mixer, gain and real-only bits plus junk in reserved bits
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            v[5:4] = i[1:0];
            bus_write(32'h00000C40, v);
            bus_read(32'h00000C40, rd);
            chk("first_downconverter_reg", v & 32'hF8, rd);
            @(negedge core_clk);
            chk("mixer_cfg", (v & 32'hF8) >> 3, {27'h0, mixer_cfg});
        end
        bus_read(32'h00000C04, rd);
        chk("unmapped", 32'h0, rd);
        bus_write(32'h00000C00, 32'hFFFFFF7C);
        bus_read(32'h00000C00, rd);
        chk("sync_reg", 32'h10, rd);
        chk("hold_reset", 32'h1, {31'h0, osc_hold_reset});
        bus_write(32'h00000C00, 32'h0);
        @(negedge core_clk);
        chk("hold_reset", 32'h0, {31'h0, osc_hold_reset});
        // Immediate mode: each word lands on its own write; untouched words keep their reset zero
        for (i = 0; i < 4; i++) applied[i] = 32'h0;
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            bus_write(32'h00000C50 + 4 * i, v);
            staged[i] = v;
            applied[i] = v;
            chk_words;
        end
        // Staged mode: nothing moves until the transfer strobe
        bus_write(32'h00000C00, 32'h80);
        for (i = 0; i < 4; i++) begin
            staged[i] = $random(seed);
            bus_write(32'h00000C50 + 4 * i, staged[i]);
        end
        chk_words;
        bus_read(32'h00000C58, rd);
        chk("staged_word", staged[2], rd);
        bus_write(32'h0000003C, 32'h1);
        for (i = 0; i < 4; i++) applied[i] = staged[i];
        chk_words;
        // One-shot then continuous alignment, timing input running only after the arm bits are set
        bus_write(32'h00000C00, 32'h83);
        burst(3, 1);
        bus_read(32'h00000C00, rd);
        chk("sync_reg", 32'h82, rd);
        burst(2, 0);
        bus_write(32'h00000C00, 32'h01);
        burst(3, 3);
        bus_read(32'h00000C00, rd);
        chk("sync_reg", 32'h01, rd);
        close_out;
    end
endmodule
